// File: hw/flta_defs.svh
`ifndef FLTA_DEFS_SVH
`define FLTA_DEFS_SVH

// Word width of monitored value and thresholds.
`define FLTA_WORD_W 16
// Number of decimal digits in a packed decimal word.
`define FLTA_DIGITS 4
// Register byte offsets.
`define FLTA_OFF_CTRL    8'h00
`define FLTA_OFF_VALUE   8'h04
`define FLTA_OFF_UU      8'h08
`define FLTA_OFF_U       8'h0C
`define FLTA_OFF_L       8'h10
`define FLTA_OFF_LL      8'h14
`define FLTA_OFF_ALARM   8'h18
`define FLTA_OFF_STATUS  8'h1C
`define FLTA_OFF_MASK    8'h20
// Control register fields.
`define FLTA_CTRL_EN     0
`define FLTA_CTRL_BCD    1
`define FLTA_CTRL_SRC    2
`define FLTA_CTRL_UUSRC  3
`define FLTA_CTRL_USRC   4
`define FLTA_CTRL_LSRC   5
`define FLTA_CTRL_LLSRC  6
// Alarm bit positions.
`define FLTA_A_UU 3
`define FLTA_A_U  2
`define FLTA_A_L  1
`define FLTA_A_LL 0
// AXI responses.
`define FLTA_RESP_OKAY   2'b00
`define FLTA_RESP_SLVERR 2'b10

`endif

// File: hw/flta_pkg.sv
package flta_pkg;
	// Comparison mode of the monitor.
	typedef enum logic {
		FLTA_MODE_BINARY,
		FLTA_MODE_DECIMAL
	} flta_mode_t;
endpackage

// File: hw/flta_compare.sv
`timescale 1ns/100ps
`include "flta_defs.svh"
// Registered four-level comparator; one cycle from inputs to alarms.
module flta_compare #(
	parameter int WORD_W = `FLTA_WORD_W
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Operands
	input  wire logic              enable,
	input  flta_pkg::flta_mode_t   mode,
	input  wire logic [WORD_W-1:0] value,
	input  wire logic [WORD_W-1:0] thr_uu,
	input  wire logic [WORD_W-1:0] thr_u,
	input  wire logic [WORD_W-1:0] thr_l,
	input  wire logic [WORD_W-1:0] thr_ll,
	// Result
	output logic      [3:0]        alarm
);
	initial begin
		if (WORD_W != 4 * `FLTA_DIGITS)
			$error("flta_compare: WORD_W must hold the decimal digits");
	end

	// Packed decimal with valid digits orders like plain binary, so one comparator serves both modes.
	// An invalid digit (A..F) is clamped to 9 so decimal mode never ranks it above a real nine.
	function automatic logic [WORD_W-1:0] fix_dec(input logic [WORD_W-1:0] w);
		logic [WORD_W-1:0] r;
		r = w;
		for (int d = 0; d < `FLTA_DIGITS; d++) begin
			if (w[4*d +: 4] > 4'h9)
				r[4*d +: 4] = 4'h9;
		end
		return r;
	endfunction

	logic [WORD_W-1:0] v;
	logic [WORD_W-1:0] t_uu;
	logic [WORD_W-1:0] t_u;
	logic [WORD_W-1:0] t_l;
	logic [WORD_W-1:0] t_ll;
	logic [3:0]        next_alarm;

	always_comb begin
		v    = value;
		t_uu = thr_uu;
		t_u  = thr_u;
		t_l  = thr_l;
		t_ll = thr_ll;
		if (mode == flta_pkg::FLTA_MODE_DECIMAL) begin
			v    = fix_dec(value);
			t_uu = fix_dec(thr_uu);
			t_u  = fix_dec(thr_u);
			t_l  = fix_dec(thr_l);
			t_ll = fix_dec(thr_ll);
		end
		next_alarm = 4'h0;
		if (enable) begin
			next_alarm[`FLTA_A_UU] = (v >= t_uu);
			next_alarm[`FLTA_A_LL] = (v <= t_ll);
			// Inner alarms follow outer ones, so a shared threshold yields one consistent result.
			next_alarm[`FLTA_A_U]  = (v >= t_u) | next_alarm[`FLTA_A_UU];
			next_alarm[`FLTA_A_L]  = (v <= t_l) | next_alarm[`FLTA_A_LL];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			alarm <= 4'h0;
		else
			alarm <= next_alarm;
	end

	AST_UPPER_IMPLIED: assert property (@(posedge clk) disable iff (rst)
		alarm[`FLTA_A_UU] |-> alarm[`FLTA_A_U]) else $error("upper-upper without upper");
	AST_LOWER_IMPLIED: assert property (@(posedge clk) disable iff (rst)
		alarm[`FLTA_A_LL] |-> alarm[`FLTA_A_L]) else $error("lower-lower without lower");
	AST_DISABLED_CLEAR: assert property (@(posedge clk) disable iff (rst)
		!enable |=> alarm == 4'h0) else $error("alarms not cleared when disabled");
	AST_UU_INCLUSIVE: assert property (@(posedge clk) disable iff (rst)
		enable && v >= t_uu |=> alarm[`FLTA_A_UU]) else $error("upper-upper missed");
	AST_LL_INCLUSIVE: assert property (@(posedge clk) disable iff (rst)
		enable && v <= t_ll |=> alarm[`FLTA_A_LL]) else $error("lower-lower missed");
	AST_U_EXACT: assert property (@(posedge clk) disable iff (rst)
		enable |=> alarm[`FLTA_A_U] == ($past(v) >= $past(t_u) || $past(v) >= $past(t_uu)))
		else $error("upper alarm wrong");
	AST_L_EXACT: assert property (@(posedge clk) disable iff (rst)
		enable |=> alarm[`FLTA_A_L] == ($past(v) <= $past(t_l) || $past(v) <= $past(t_ll)))
		else $error("lower alarm wrong");
	AST_SHARED_UPPER: assert property (@(posedge clk) disable iff (rst)
		enable && t_uu == t_u |=> alarm[`FLTA_A_UU] == alarm[`FLTA_A_U]) else $error("shared upper split");
	AST_DEC_CLAMP: assert property (@(posedge clk) disable iff (rst)
		enable && mode == flta_pkg::FLTA_MODE_DECIMAL && value == 16'h00_0A && thr_uu == 16'h00_09 |=>
		alarm[`FLTA_A_UU]) else $error("decimal compare wrong");

	COV_UPPER_BOTH: cover property (@(posedge clk) disable iff (rst) alarm[`FLTA_A_UU] && alarm[`FLTA_A_U]);
	COV_LOWER_BOTH: cover property (@(posedge clk) disable iff (rst) alarm[`FLTA_A_LL] && alarm[`FLTA_A_L]);
	COV_ONLY_UPPER: cover property (@(posedge clk) disable iff (rst) alarm == 4'b0100);
	COV_DECIMAL:    cover property (@(posedge clk) disable iff (rst)
		mode == flta_pkg::FLTA_MODE_DECIMAL && enable ##1 alarm != 4'h0);
endmodule // flta_compare

// File: hw/flta_top.sv
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "flta_defs.svh"
module flta_top #(
	parameter int WORD_W = `FLTA_WORD_W
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Enable and monitored data from the control logic
	input  wire logic              enable,
	input  wire logic [WORD_W-1:0] mon_value,
	input  wire logic [WORD_W-1:0] mem_uu,
	input  wire logic [WORD_W-1:0] mem_u,
	input  wire logic [WORD_W-1:0] mem_l,
	input  wire logic [WORD_W-1:0] mem_ll,
	// Alarms and interrupt
	output logic      [3:0]        alarm,
	output logic                   irq,
	// AXI4-Lite write address
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic      [31:0]       s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	initial begin
		if (WORD_W != `FLTA_WORD_W)
			$error("flta_top: WORD_W must be the documented word width");
	end

	// Software state.
	logic [6:0]        ctrl;
	logic [WORD_W-1:0] sw_value;
	logic [WORD_W-1:0] k_uu;
	logic [WORD_W-1:0] k_u;
	logic [WORD_W-1:0] k_l;
	logic [WORD_W-1:0] k_ll;
	logic [3:0]        status;
	logic [3:0]        mask;
	logic [6:0]        next_ctrl;
	logic [WORD_W-1:0] next_sw_value;
	logic [WORD_W-1:0] next_k_uu;
	logic [WORD_W-1:0] next_k_u;
	logic [WORD_W-1:0] next_k_l;
	logic [WORD_W-1:0] next_k_ll;
	logic [3:0]        next_status;
	logic [3:0]        next_mask;

	// Bus state.
	logic              aw_held;
	logic [7:0]        aw_addr;
	logic              w_held;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              next_aw_held;
	logic [7:0]        next_aw_addr;
	logic              next_w_held;
	logic [31:0]       next_w_data;
	logic [3:0]        next_w_strb;
	logic              next_bvalid;
	logic [1:0]        next_bresp;
	logic              next_rvalid;
	logic [31:0]       next_rdata;
	logic [1:0]        next_rresp;
	logic              next_irq;
	logic [3:0]        alarm_q;

	// Operand selection.
	logic              sel_enable;
	logic [WORD_W-1:0] sel_value;
	logic [WORD_W-1:0] sel_uu;
	logic [WORD_W-1:0] sel_u;
	logic [WORD_W-1:0] sel_l;
	logic [WORD_W-1:0] sel_ll;
	logic [3:0]        rise;
	flta_pkg::flta_mode_t sel_mode;

	// Each threshold comes either from a software constant or from the live memory word.
	always_comb begin
		sel_enable = enable & ctrl[`FLTA_CTRL_EN];
		sel_mode   = ctrl[`FLTA_CTRL_BCD] ? flta_pkg::FLTA_MODE_DECIMAL : flta_pkg::FLTA_MODE_BINARY;
		sel_value  = ctrl[`FLTA_CTRL_SRC] ? sw_value : mon_value;
		sel_uu     = ctrl[`FLTA_CTRL_UUSRC] ? mem_uu : k_uu;
		sel_u      = ctrl[`FLTA_CTRL_USRC] ? mem_u : k_u;
		sel_l      = ctrl[`FLTA_CTRL_LSRC] ? mem_l : k_l;
		sel_ll     = ctrl[`FLTA_CTRL_LLSRC] ? mem_ll : k_ll;
	end

	flta_compare #(
		.WORD_W (WORD_W)
	) u_compare (
		.clk    (clk),
		.rst    (rst),
		.enable (sel_enable),
		.mode   (sel_mode),
		.value  (sel_value),
		.thr_uu (sel_uu),
		.thr_u  (sel_u),
		.thr_l  (sel_l),
		.thr_ll (sel_ll),
		.alarm  (alarm_q)
	);

	// Registers store what software wrote without range checks; ordering is the supplier's duty.
	function automatic logic [WORD_W-1:0] merge16(input logic [WORD_W-1:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [WORD_W-1:0] r;
		r = old;
		if (s[0])
			r[7:0] = d[7:0];
		if (s[1])
			r[15:8] = d[15:8];
		return r;
	endfunction

	logic do_write;
	logic do_read;
	logic wr_hit;
	logic rd_hit;

	always_comb begin
		next_ctrl     = ctrl;
		next_sw_value = sw_value;
		next_k_uu     = k_uu;
		next_k_u      = k_u;
		next_k_l      = k_l;
		next_k_ll     = k_ll;
		next_mask     = mask;
		next_aw_held  = aw_held | (s_axi_awvalid & s_axi_awready);
		next_aw_addr  = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : aw_addr;
		next_w_held   = w_held | (s_axi_wvalid & s_axi_wready);
		next_w_data   = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : w_data;
		next_w_strb   = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : w_strb;
		next_bvalid   = s_axi_bvalid & ~s_axi_bready;
		next_bresp    = s_axi_bresp;
		next_rvalid   = s_axi_rvalid & ~s_axi_rready;
		next_rdata    = s_axi_rdata;
		next_rresp    = s_axi_rresp;
		rise          = alarm_q & ~alarm;
		wr_hit        = 1'b1;
		rd_hit        = 1'b1;
		do_write      = aw_held & w_held & ~s_axi_bvalid;
		do_read       = s_axi_arvalid & s_axi_arready;
		// A new alarm rise wins over a clear written in the same cycle.
		next_status   = status;
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			unique case (aw_addr)
				`FLTA_OFF_CTRL:   if (w_strb[0]) next_ctrl = w_data[6:0];
				`FLTA_OFF_VALUE:  next_sw_value = merge16(sw_value, w_data, w_strb);
				`FLTA_OFF_UU:     next_k_uu = merge16(k_uu, w_data, w_strb);
				`FLTA_OFF_U:      next_k_u = merge16(k_u, w_data, w_strb);
				`FLTA_OFF_L:      next_k_l = merge16(k_l, w_data, w_strb);
				`FLTA_OFF_LL:     next_k_ll = merge16(k_ll, w_data, w_strb);
				`FLTA_OFF_ALARM:  wr_hit = 1'b1;
				`FLTA_OFF_STATUS: if (w_strb[0]) next_status = status & ~w_data[3:0];
				`FLTA_OFF_MASK:   if (w_strb[0]) next_mask = w_data[3:0];
				default:          wr_hit = 1'b0;
			endcase
			next_bresp = wr_hit ? `FLTA_RESP_OKAY : `FLTA_RESP_SLVERR;
		end
		next_status = next_status | rise;
		if (do_read) begin
			next_rvalid = 1'b1;
			next_rdata  = 32'h0000_0000;
			unique case (s_axi_araddr)
				`FLTA_OFF_CTRL:   next_rdata[6:0] = ctrl;
				`FLTA_OFF_VALUE:  next_rdata[WORD_W-1:0] = sw_value;
				`FLTA_OFF_UU:     next_rdata[WORD_W-1:0] = k_uu;
				`FLTA_OFF_U:      next_rdata[WORD_W-1:0] = k_u;
				`FLTA_OFF_L:      next_rdata[WORD_W-1:0] = k_l;
				`FLTA_OFF_LL:     next_rdata[WORD_W-1:0] = k_ll;
				`FLTA_OFF_ALARM:  next_rdata[3:0] = alarm;
				`FLTA_OFF_STATUS: next_rdata[3:0] = status;
				`FLTA_OFF_MASK:   next_rdata[3:0] = mask;
				default:          rd_hit = 1'b0;
			endcase
			next_rresp = rd_hit ? `FLTA_RESP_OKAY : `FLTA_RESP_SLVERR;
		end
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl          <= 7'h00;
			sw_value      <= 16'h0000;
			k_uu          <= 16'h0000;
			k_u           <= 16'h0000;
			k_l           <= 16'h0000;
			k_ll          <= 16'h0000;
			status        <= 4'h0;
			mask          <= 4'h0;
			aw_held       <= 1'b0;
			aw_addr       <= 8'h00;
			w_held        <= 1'b0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
			alarm         <= 4'h0;
			irq           <= 1'b0;
		end else begin
			ctrl          <= next_ctrl;
			sw_value      <= next_sw_value;
			k_uu          <= next_k_uu;
			k_u           <= next_k_u;
			k_l           <= next_k_l;
			k_ll          <= next_k_ll;
			status        <= next_status;
			mask          <= next_mask;
			aw_held       <= next_aw_held;
			aw_addr       <= next_aw_addr;
			w_held        <= next_w_held;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			// Ready is offered only while the slot is empty, so one write is in flight.
			s_axi_awready <= ~next_aw_held & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready  <= ~next_w_held & ~(s_axi_wvalid & s_axi_wready);
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= ~next_rvalid & ~(s_axi_arvalid & s_axi_arready);
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
			alarm         <= alarm_q;
			irq           <= next_irq;
		end
	end

	AST_STATUS_STICKY: assert property (@(posedge clk) disable iff (rst)
		(alarm_q & ~alarm) != 4'h0 |=> (status & $past(alarm_q & ~alarm)) == $past(alarm_q & ~alarm))
		else $error("alarm rise not latched");
	AST_ALARM_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
		!enable ##1 1'b1 |=> alarm == 4'h0) else $error("alarm output not cleared");
	COV_IRQ: cover property (@(posedge clk) disable iff (rst) $rose(irq));
endmodule // flta_top

// File: testbench/flta_partner.sv
`timescale 1ns/100ps
// Control-logic side of the monitor: holds the four threshold memory words.
module flta_partner (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Load request from the bench
	input  wire logic        ld,
	input  wire logic [63:0] words,
	// Memory words seen by the monitor
	output logic      [15:0] mem_uu,
	output logic      [15:0] mem_u,
	output logic      [15:0] mem_l,
	output logic      [15:0] mem_ll
);
	logic ordered;

	// An unordered set is dropped, so apart from the all-zero reset words the monitor never sees limits that the supplier may not give.
	assign ordered = (words[63:48] >= words[47:32]) && (words[47:32] > words[31:16]) && (words[31:16] >= words[15:0]);

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			{mem_uu, mem_u, mem_l, mem_ll} <= 64'h0000_0000_0000_0000;
		else if (ld && ordered)
			{mem_uu, mem_u, mem_l, mem_ll} <= words;
	end
endmodule // flta_partner

// File: testbench/four_level_threshold_alarm_tb_top.sv
`timescale 1ns/100ps
`include "flta_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module four_level_threshold_alarm_tb_top;
	logic        clk = 1'h0, rst = 1'h1, enable = 1'h0, ld = 1'h0, pulse = 1'h0, irq;
	logic [63:0] words = 64'h0000_0000_0000_0000, w;
	logic [15:0] mon_value = 16'h0000, mem_uu, mem_u, mem_l, mem_ll, v;
	logic [3:0]  alarm, s_axi_wstrb = 4'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, eb;
	logic [4:0]  q_al[$], ea;
	logic [33:0] q_rd[$], er;
	logic [1:0]  q_b[$];
	int          error_cnt = 0, checks = 0, r0, r1, r2, r3;
	int          vals[10] = '{1000, 999, 900, 899, 500, 201, 200, 101, 100, 0};

	flta_partner partner_u (.clk(clk), .rst(rst), .ld(ld), .words(words),
		.mem_uu(mem_uu), .mem_u(mem_u), .mem_l(mem_l), .mem_ll(mem_ll));
	flta_top #(.WORD_W(16)) dut_u (.clk(clk), .rst(rst), .enable(enable), .mon_value(mon_value),
		.mem_uu(mem_uu), .mem_u(mem_u), .mem_l(mem_l), .mem_ll(mem_ll), .alarm(alarm), .irq(irq),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic final_report();
		$display("Mismatches %0d of %0d comparisons", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Handshakes are judged at the falling edge, where ready and valid are steady up to the taking edge.
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_t, w_t, b_t;
		q_b.push_back(r);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= 4'hf;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		for (int i = 0; i < 50; i++) begin
			@(negedge clk);
			aw_t = s_axi_awvalid & s_axi_awready;
			w_t  = s_axi_wvalid & s_axi_wready;
			b_t  = s_axi_bvalid;
			@(posedge clk);
			if (aw_t) s_axi_awvalid <= 1'h0;
			if (w_t) s_axi_wvalid <= 1'h0;
			if (b_t) begin
				s_axi_bready <= 1'h0;
				// One idle edge keeps the next call from raising bready in the same time step.
				@(posedge clk);
				return;
			end
		end
		error_cnt++;
		final_report();
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ar_t, r_t;
		q_rd.push_back({r, d});
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		for (int i = 0; i < 50; i++) begin
			@(negedge clk);
			ar_t = s_axi_arvalid & s_axi_arready;
			r_t  = s_axi_rvalid;
			@(posedge clk);
			if (ar_t) s_axi_arvalid <= 1'h0;
			if (r_t) begin
				s_axi_rready <= 1'h0;
				@(posedge clk);
				return;
			end
		end
		error_cnt++;
		final_report();
	endtask

	function automatic int mag(input logic [15:0] x, input logic dec);
		return dec ? x[15:12] * 1000 + x[11:8] * 100 + x[7:4] * 10 + x[3:0] : int'(x);
	endfunction

	function automatic logic [15:0] enc(input int n, input logic dec);
		return dec ? {4'(n / 1000 % 10), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)} : 16'(n);
	endfunction

	function automatic logic [3:0] exp_al(input logic [15:0] x, input logic [63:0] t, input logic dec);
		logic hi2, hi1, lo1, lo2;
		hi2 = mag(x, dec) >= mag(t[63:48], dec);
		hi1 = hi2 | (mag(x, dec) >= mag(t[47:32], dec));
		lo2 = mag(x, dec) <= mag(t[15:0], dec);
		lo1 = lo2 | (mag(x, dec) <= mag(t[31:16], dec));
		return {hi2, hi1, lo1, lo2};
	endfunction

	// Two monitor edges and the status edge lie inside the five-cycle wait; the partner load comes on the edge before it.
	task automatic chk_al(input logic [4:0] e);
		q_al.push_back(e);
		repeat (5) @(posedge clk);
		pulse <= 1'h1;
		@(posedge clk);
		pulse <= 1'h0;
	endtask

	task automatic apply(input logic en, input logic [15:0] x, input logic [63:0] t, input logic dec, input logic ir);
		enable    <= en;
		mon_value <= x;
		words     <= t;
		ld        <= 1'h1;
		@(posedge clk);
		ld <= 1'h0;
		chk_al({ir, en ? exp_al(x, t, dec) : 4'h0});
	endtask

	always @(negedge clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			er = q_rd.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, er)
		end
		if (s_axi_bvalid && s_axi_bready) begin
			eb = q_b.pop_front();
			`CHK(s_axi_bresp, eb)
		end
		if (pulse) begin
			ea = q_al.pop_front();
			`CHK({irq, alarm}, ea)
		end
	end

	initial begin
		void'($urandom(32'h0000_dc1c));
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		axr(`FLTA_OFF_CTRL, 32'h0000_0000, `FLTA_RESP_OKAY);
		axr(`FLTA_OFF_UU, 32'h0000_0000, `FLTA_RESP_OKAY);
		axr(8'h24, 32'h0000_0000, `FLTA_RESP_SLVERR);
		axw(8'h24, 32'h0000_ffff, `FLTA_RESP_SLVERR);
		axw(`FLTA_OFF_UU, 32'h0000_1234, `FLTA_RESP_OKAY);
		axr(`FLTA_OFF_UU, 32'h0000_1234, `FLTA_RESP_OKAY);
		axw(`FLTA_OFF_ALARM, 32'h0000_000f, `FLTA_RESP_OKAY);
		axr(`FLTA_OFF_ALARM, 32'h0000_0000, `FLTA_RESP_OKAY);
		// Value from the port, all four limits from the memory words.
		for (int dec = 0; dec < 2; dec++) begin
			axw(`FLTA_OFF_CTRL, dec ? 32'h0000_007b : 32'h0000_0079, `FLTA_RESP_OKAY);
			for (int s = 0; s < 2; s++) begin
				w = s ? {enc(900, dec), enc(900, dec), enc(200, dec), enc(200, dec)}
					: {enc(1000, dec), enc(900, dec), enc(200, dec), enc(100, dec)};
				for (int k = 0; k < 11; k++) begin
					v = (k == 10) ? (dec ? 16'h9999 : 16'hffff) : enc(vals[k], dec);
					apply(!(s == 1 && k == 0), v, w, dec[0], 1'h0);
				end
			end
		end
		axw(`FLTA_OFF_CTRL, 32'h0000_0079, `FLTA_RESP_OKAY);
		for (int i = 0; i < 24; i++) begin
			r3 = $urandom_range(16'hfffe, 0);
			r2 = $urandom_range(16'hfffe, r3);
			r1 = $urandom_range(16'hffff, r2 + 1);
			r0 = $urandom_range(16'hffff, r1);
			w = {16'(r0), 16'(r1), 16'(r2), 16'(r3)};
			v = i[0] ? w[16 * (i % 4) +: 16] : 16'($urandom_range(16'hffff, 0));
			apply(1'h1, v, w, 1'h0, 1'h0);
		end
		w = {16'h03e8, 16'h0384, 16'h00c8, 16'h0064};
		apply(1'h1, 16'h01f4, w, 1'h0, 1'h0);
		axw(`FLTA_OFF_STATUS, 32'h0000_000f, `FLTA_RESP_OKAY);
		axw(`FLTA_OFF_MASK, 32'h0000_000f, `FLTA_RESP_OKAY);
		axr(`FLTA_OFF_STATUS, 32'h0000_0000, `FLTA_RESP_OKAY);
		apply(1'h1, 16'h0032, w, 1'h0, 1'h1);
		axr(`FLTA_OFF_STATUS, 32'h0000_0003, `FLTA_RESP_OKAY);
		axw(`FLTA_OFF_MASK, 32'h0000_0000, `FLTA_RESP_OKAY);
		apply(1'h1, 16'h0032, w, 1'h0, 1'h0);
		axw(`FLTA_OFF_MASK, 32'h0000_0002, `FLTA_RESP_OKAY);
		apply(1'h1, 16'h0032, w, 1'h0, 1'h1);
		axw(`FLTA_OFF_STATUS, 32'h0000_0002, `FLTA_RESP_OKAY);
		apply(1'h1, 16'h0032, w, 1'h0, 1'h0);
		axr(`FLTA_OFF_STATUS, 32'h0000_0001, `FLTA_RESP_OKAY);
		// A non-decimal digit in the value must still rank at or above a real nine.
		axw(`FLTA_OFF_CTRL, 32'h0000_007b, `FLTA_RESP_OKAY);
		apply(1'h1, 16'h000a, {16'h0009, 16'h0009, 16'h0002, 16'h0001}, 1'h1, 1'h0);
		// A reset in mid-run must drop live alarms at once.
		rst <= 1'h1;
		chk_al(5'h00);
		rst <= 1'h0;
		@(posedge clk);
		axr(`FLTA_OFF_CTRL, 32'h0000_0000, `FLTA_RESP_OKAY);
		final_report();
	end
endmodule // four_level_threshold_alarm_tb_top
